/* File: design/usd_fifo.sv */
`timescale 1ns/1ps
module usd_fifo (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  usd_fifo_if.store   fifo
);

  logic [usd_pkg::DATA_W-1:0] mem [usd_pkg::FIFO_DEPTH];
  logic [usd_pkg::PTR_W-1:0]  wr_ptr;
  logic [usd_pkg::PTR_W-1:0]  rd_ptr;
  logic [usd_pkg::CNT_W-1:0]  count;
  logic                       do_push;
  logic                       do_pop;

  // ****************************************
  // Flags
  // ****************************************
  // Push while full is blocked here too, so a caller slip cannot corrupt data
  assign do_push = fifo.push & (count != usd_pkg::FIFO_FULL_CNT);
  assign do_pop = fifo.pop & (count != '0);
  assign fifo.full = (count == usd_pkg::FIFO_FULL_CNT);
  assign fifo.empty = (count == '0);
  assign fifo.count = count;
  assign fifo.head = mem[rd_ptr];

  // Storage, no reset needed on the array
  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wr_ptr] <= fifo.push_data;
    end
  end

  // Pointers and fill level; flush empties the queue at once
  always_ff @(posedge aclk) begin
    if (!aresetn || fifo.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      count <= count + {4'h0, do_push} - {4'h0, do_pop};
    end
  end

endmodule : usd_fifo

/* File: design/usd_fifo_if.sv */
`timescale 1ns/1ps
// Push and pop port of one byte queue
interface usd_fifo_if;
  logic                        push;
  logic [usd_pkg::DATA_W-1:0]  push_data;
  logic                        pop;
  logic                        flush;
  logic [usd_pkg::DATA_W-1:0]  head;
  logic                        full;
  logic                        empty;
  logic [usd_pkg::CNT_W-1:0]   count;

  modport store (input push, input push_data, input pop, input flush,
                 output head, output full, output empty, output count);
  modport client (output push, output push_data, output pop, output flush,
                  input head, input full, input empty, input count);
endinterface : usd_fifo_if

/* File: design/usd_pkg.sv */
package usd_pkg;

  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
  localparam int INT_W = 4;

  // ****************************************
  // Byte addresses
  // ****************************************
  // Sixteen word aliases of the shadow data port, base and last word
  localparam logic [31:0] ALIAS_BASE_ADDR = 32'h5000_1030;
  localparam logic [31:0] ALIAS_LAST_ADDR = 32'h5000_106c;
  localparam logic [31:0] SHADOW_RX_TX_DATA_2_ADDR = 32'h5000_1038;
  localparam logic [31:0] SHADOW_RX_TX_DATA_3_ADDR = 32'h5000_103c;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1080;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1084;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_1088;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5000_108c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_MODE_BIT = 1;
  localparam int LSR_DATA_READY_BIT = 0;
  localparam int LSR_OVERRUN_BIT = 1;
  localparam int LSR_THR_EMPTY_BIT = 5;
  localparam int INT_RX_DATA_BIT = 0;
  localparam int INT_OVERRUN_BIT = 1;
  localparam int INT_TX_EMPTY_BIT = 2;
  localparam int INT_TX_LOST_BIT = 3;

  // ****************************************
  // Reset values and responses
  // ****************************************
  localparam logic [DATA_W-1:0] SHADOW_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_ALIAS = 3'b001,
    SEL_CTRL  = 3'b010,
    SEL_LSR   = 3'b011,
    SEL_ISTAT = 3'b100,
    SEL_IMASK = 3'b101
  } usd_sel_e;

endpackage : usd_pkg

/* File: design/usd_shadow_data_port.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Sixteen word aliases reach the receive buffer
// - Read returns byte from serial or infrared input
// - Read byte valid only while data ready set
// - FIFO off: new byte overwrites, flags overrun
// - FIFO on: read returns and pops head
// - Full receive FIFO drops new byte, overrun
// - Write supplies byte for serial or infrared output
// - FIFO off: one write clears holding empty
// - FIFO off: further write overwrites pending byte
// - FIFO on: sixteen writes fill transmit FIFO
// - Write to full transmit FIFO is lost
module usd_shadow_data_port (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [31:0]                 awaddr,
  input  wire logic                        awvalid,
  output wire logic                        awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output wire logic                        wready,
  output      logic [1:0]                  bresp,
  output      logic                        bvalid,
  input  wire logic                        bready,
  input  wire logic [31:0]                 araddr,
  input  wire logic                        arvalid,
  output wire logic                        arready,
  output      logic [31:0]                 rdata,
  output      logic [1:0]                  rresp,
  output      logic                        rvalid,
  input  wire logic                        rready,
  input  wire logic                        rx_uart_valid,
  input  wire logic [usd_pkg::DATA_W-1:0]  rx_uart_byte,
  input  wire logic                        rx_ir_valid,
  input  wire logic [usd_pkg::DATA_W-1:0]  rx_ir_byte,
  output wire logic                        tx_valid,
  output wire logic [usd_pkg::DATA_W-1:0]  tx_byte,
  input  wire logic                        tx_ready,
  output wire logic                        tx_ir_select,
  output wire logic                        irq
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic usd_pkg::usd_sel_e usd_decode(input logic [31:0] addr);
    usd_pkg::usd_sel_e sel;
    sel = usd_pkg::SEL_NONE;
    if (addr[1:0] != 2'h0) begin
      sel = usd_pkg::SEL_NONE;
    end else if (addr >= usd_pkg::ALIAS_BASE_ADDR && addr <= usd_pkg::ALIAS_LAST_ADDR) begin
      sel = usd_pkg::SEL_ALIAS;
    end else if (addr == usd_pkg::CTRL_ADDR) begin
      sel = usd_pkg::SEL_CTRL;
    end else if (addr == usd_pkg::LINE_STATUS_ADDR) begin
      sel = usd_pkg::SEL_LSR;
    end else if (addr == usd_pkg::INT_STATUS_ADDR) begin
      sel = usd_pkg::SEL_ISTAT;
    end else if (addr == usd_pkg::INT_MASK_ADDR) begin
      sel = usd_pkg::SEL_IMASK;
    end
    return sel;
  endfunction : usd_decode

  usd_fifo_if rx_q ();
  usd_fifo_if tx_q ();

  logic                        aw_got;
  logic [31:0]                 aw_addr;
  logic                        w_got;
  logic [31:0]                 w_data;
  logic [3:0]                  w_strb;
  logic                        do_write;
  logic                        ar_take;
  usd_pkg::usd_sel_e           wr_sel;
  usd_pkg::usd_sel_e           rd_sel;
  logic                        wr_alias;
  logic                        rd_alias;
  logic                        fifo_en;
  logic                        ir_mode;
  logic                        fifo_toggle;
  logic                        rx_in_valid;
  logic [usd_pkg::DATA_W-1:0]  rx_in_byte;
  logic [usd_pkg::DATA_W-1:0]  rx_hold;
  logic                        rx_hold_valid;
  logic [usd_pkg::DATA_W-1:0]  tx_hold;
  logic                        tx_hold_valid;
  logic                        data_ready;
  logic                        thr_empty;
  logic                        thr_empty_q;
  logic                        overrun_event;
  logic                        overrun;
  logic                        tx_lost_event;
  logic [usd_pkg::INT_W-1:0]   int_event;
  logic [usd_pkg::INT_W-1:0]   int_status;
  logic [usd_pkg::INT_W-1:0]   int_mask;
  logic [usd_pkg::INT_W-1:0]   int_clear;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  // Address and data are taken independently; the write acts once both are in
  assign awready = ~aw_got;
  assign wready = ~w_got;
  assign do_write = aw_got & w_got & ~bvalid;
  assign wr_sel = usd_decode(aw_addr);
  assign wr_alias = do_write & (wr_sel == usd_pkg::SEL_ALIAS) & w_strb[0];

  // Write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (awvalid && awready) begin
      aw_got  <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_got <= 1'b0;
    end
  end

  // Write data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got  <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_got  <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_write) begin
      w_got <= 1'b0;
    end
  end

  // Write response one cycle after the write acts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= usd_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= (wr_sel == usd_pkg::SEL_NONE) ? usd_pkg::RESP_SLVERR : usd_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channels
  // ****************************************
  // A new address is refused while a read answer waits, so a pop is never lost
  assign arready = ~rvalid;
  assign ar_take = arvalid & arready;
  assign rd_sel = usd_decode(araddr);
  assign rd_alias = ar_take & (rd_sel == usd_pkg::SEL_ALIAS);

  // Read data mux; bits above the field stay zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = usd_pkg::RESP_OKAY;
    unique case (rd_sel)
      usd_pkg::SEL_ALIAS: begin
        next_rdata[usd_pkg::DATA_W-1:0] = fifo_en ? rx_q.head : rx_hold;
      end
      usd_pkg::SEL_CTRL: begin
        next_rdata[usd_pkg::CTRL_FIFO_EN_BIT] = fifo_en;
        next_rdata[usd_pkg::CTRL_IR_MODE_BIT] = ir_mode;
      end
      usd_pkg::SEL_LSR: begin
        next_rdata[usd_pkg::LSR_DATA_READY_BIT] = data_ready;
        next_rdata[usd_pkg::LSR_OVERRUN_BIT] = overrun;
        next_rdata[usd_pkg::LSR_THR_EMPTY_BIT] = thr_empty;
      end
      usd_pkg::SEL_ISTAT: begin
        next_rdata[usd_pkg::INT_W-1:0] = int_status;
      end
      usd_pkg::SEL_IMASK: begin
        next_rdata[usd_pkg::INT_W-1:0] = int_mask;
      end
      usd_pkg::SEL_NONE: begin
        next_rresp = usd_pkg::RESP_SLVERR;
      end
    endcase
  end

  // Read answer registered, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= usd_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Toggling the FIFO enable discards both queues and both holding bytes
  assign fifo_toggle = do_write & (wr_sel == usd_pkg::SEL_CTRL) & w_strb[0] &
                       (w_data[usd_pkg::CTRL_FIFO_EN_BIT] != fifo_en);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_en <= usd_pkg::CTRL_RESET[usd_pkg::CTRL_FIFO_EN_BIT];
      ir_mode <= usd_pkg::CTRL_RESET[usd_pkg::CTRL_IR_MODE_BIT];
    end else if (do_write && wr_sel == usd_pkg::SEL_CTRL && w_strb[0]) begin
      fifo_en <= w_data[usd_pkg::CTRL_FIFO_EN_BIT];
      ir_mode <= w_data[usd_pkg::CTRL_IR_MODE_BIT];
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  // Byte source follows the line mode
  assign rx_in_valid = ir_mode ? rx_ir_valid : rx_uart_valid;
  assign rx_in_byte = ir_mode ? rx_ir_byte : rx_uart_byte;

  // Full queue keeps its contents and the new byte is dropped
  assign rx_q.push = fifo_en & rx_in_valid & ~rx_q.full;
  assign rx_q.push_data = rx_in_byte;
  assign rx_q.pop = fifo_en & rd_alias & ~rx_q.empty;
  assign rx_q.flush = fifo_toggle;

  usd_fifo u_rx_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fifo    (rx_q)
  );

  // Single holding byte; an arrival in the read cycle keeps data ready set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold       <= usd_pkg::SHADOW_RESET;
      rx_hold_valid <= 1'b0;
    end else if (fifo_toggle) begin
      rx_hold_valid <= 1'b0;
    end else if (!fifo_en && rx_in_valid) begin
      rx_hold       <= rx_in_byte;
      rx_hold_valid <= 1'b1;
    end else if (!fifo_en && rd_alias) begin
      rx_hold_valid <= 1'b0;
    end
  end

  assign data_ready = fifo_en ? ~rx_q.empty : rx_hold_valid;
  assign overrun_event = rx_in_valid & (fifo_en ? rx_q.full : rx_hold_valid);

  // Overrun flag clears on a line status read; a new overrun wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun <= 1'b0;
    end else if (overrun_event) begin
      overrun <= 1'b1;
    end else if (ar_take && rd_sel == usd_pkg::SEL_LSR) begin
      overrun <= 1'b0;
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  assign tx_q.push = fifo_en & wr_alias & ~tx_q.full;
  assign tx_q.push_data = w_data[usd_pkg::DATA_W-1:0];
  assign tx_q.pop = fifo_en & tx_ready & ~tx_q.empty;
  assign tx_q.flush = fifo_toggle;
  assign tx_lost_event = fifo_en & wr_alias & tx_q.full;

  usd_fifo u_tx_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fifo    (tx_q)
  );

  // Holding byte; a write in the cycle the transmitter takes it stays pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold       <= usd_pkg::SHADOW_RESET;
      tx_hold_valid <= 1'b0;
    end else if (fifo_toggle) begin
      tx_hold_valid <= 1'b0;
    end else if (!fifo_en && wr_alias) begin
      tx_hold       <= w_data[usd_pkg::DATA_W-1:0];
      tx_hold_valid <= 1'b1;
    end else if (!fifo_en && tx_ready) begin
      tx_hold_valid <= 1'b0;
    end
  end

  // Byte offered to the serialiser, which picks the pin by the mode
  assign tx_valid = fifo_en ? ~tx_q.empty : tx_hold_valid;
  assign tx_byte = fifo_en ? tx_q.head : tx_hold;
  assign tx_ir_select = ir_mode;
  assign thr_empty = fifo_en ? tx_q.empty : ~tx_hold_valid;

  // Delayed copy to catch the holding empty rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_empty_q <= 1'b1;
    end else begin
      thr_empty_q <= thr_empty;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign int_event[usd_pkg::INT_RX_DATA_BIT] = rx_q.push | (~fifo_en & rx_in_valid);
  assign int_event[usd_pkg::INT_OVERRUN_BIT] = overrun_event;
  assign int_event[usd_pkg::INT_TX_EMPTY_BIT] = thr_empty & ~thr_empty_q;
  assign int_event[usd_pkg::INT_TX_LOST_BIT] = tx_lost_event;
  assign int_clear = (do_write && wr_sel == usd_pkg::SEL_ISTAT && w_strb[0]) ?
                     w_data[usd_pkg::INT_W-1:0] : '0;

  // Sticky bits, write one to clear; an event in the clear cycle wins
  for (genvar i = 0; i < usd_pkg::INT_W; i++) begin : g_int
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        int_status[i] <= 1'b0;
      end else if (int_event[i]) begin
        int_status[i] <= 1'b1;
      end else if (int_clear[i]) begin
        int_status[i] <= 1'b0;
      end
    end
  end

  // Mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= usd_pkg::INT_MASK_RESET;
    end else if (do_write && wr_sel == usd_pkg::SEL_IMASK && w_strb[0]) begin
      int_mask <= w_data[usd_pkg::INT_W-1:0];
    end
  end

  assign irq = |(int_status & int_mask);

endmodule : usd_shadow_data_port

/* File: testbench/test_uart_shadow_data_port.sv */
`timescale 1ns/1ps
module test_uart_shadow_data_port;
  // ****************************************
  // Bench signals and instances
  // ****************************************
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, tx_ir_select, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic        rx_uart_valid, rx_ir_valid;
  logic [7:0]  rx_uart_byte, rx_ir_byte, tx_byte;
  int          num_errors = 0, check_count = 0, cycles = 0;

  always #12.5 aclk = ~aclk;

  usd_shadow_data_port DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rx_uart_valid(rx_uart_valid), .rx_uart_byte(rx_uart_byte),
    .rx_ir_valid(rx_ir_valid), .rx_ir_byte(rx_ir_byte), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_ir_select(tx_ir_select), .irq(irq));

  usd_serial_partner P (.aclk(aclk), .aresetn(aresetn), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_uart_valid(rx_uart_valid),
    .rx_uart_byte(rx_uart_byte), .rx_ir_valid(rx_ir_valid), .rx_ir_byte(rx_ir_byte));

  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Address and data offered together, each released once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
      end
    end
    check(rd, exp);
  endtask : rchk

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_idle();
    rchk(usd_pkg::SHADOW_RX_TX_DATA_2_ADDR, 32'h0);
    rchk(usd_pkg::SHADOW_RX_TX_DATA_3_ADDR, 32'h0);
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h20);
    rchk(32'h5000_1090, 32'h0);
    check(32'(rsp), 32'(usd_pkg::RESP_SLVERR));
    // Misaligned word inside the alias block is refused and loads nothing
    wr(32'h5000_1032, 32'h77);
    check(32'(rsp), 32'(usd_pkg::RESP_SLVERR));
    check(32'(tx_valid), 32'h0);
  endtask : t_idle

  // Unread byte is overwritten, then infrared source replaces serial
  task automatic t_rx();
    P.send(1'b0, 8'h5a);
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h21);
    P.send(1'b0, 8'ha5);
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h23);
    rchk(usd_pkg::SHADOW_RX_TX_DATA_3_ADDR, 32'ha5);
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h20);
    wr(usd_pkg::INT_MASK_ADDR, 32'h2);
    check(32'(irq), 32'h1);
    wr(usd_pkg::INT_STATUS_ADDR, 32'h2);
    check(32'(irq), 32'h0);
    rchk(usd_pkg::INT_STATUS_ADDR, 32'h1);
    wr(usd_pkg::CTRL_ADDR, 32'h2);
    check(32'(tx_ir_select), 32'h1);
    P.send(1'b1, 8'h3c);
    P.send(1'b0, 8'hee);
    rchk(usd_pkg::ALIAS_LAST_ADDR, 32'h3c);
    wr(usd_pkg::CTRL_ADDR, 32'h0);
    check(32'(tx_ir_select), 32'h0);
    wr(usd_pkg::INT_STATUS_ADDR, 32'hf);
    wr(usd_pkg::INT_MASK_ADDR, 32'h0);
  endtask : t_rx

  // Second write lands before the serialiser takes the first
  task automatic t_tx();
    P.stall <= 1'b1;
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h20);
    wr(usd_pkg::SHADOW_RX_TX_DATA_2_ADDR, 32'h111);
    check(32'(rsp), 32'(usd_pkg::RESP_OKAY));
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h0);
    wr(usd_pkg::ALIAS_BASE_ADDR, 32'h22);
    check(32'(tx_byte), 32'h22);
    check(32'(tx_valid), 32'h1);
    P.stall <= 1'b0;
    while (P.got.size() < 1) @(posedge aclk);
    repeat (4) @(posedge aclk);
    check(32'(P.got.size()), 32'h1);
    check(32'(P.got[0]), 32'h22);
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h20);
    wr(usd_pkg::INT_STATUS_ADDR, 32'hf);
  endtask : t_tx

  // Both queues driven one past full while the far side stalls
  task automatic t_fifo();
    P.stall <= 1'b1;
    wr(usd_pkg::CTRL_ADDR, 32'h1);
    for (int i = 0; i < 17; i++) wr(usd_pkg::ALIAS_BASE_ADDR + 32'(4 * (i % 16)), 32'(i));
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h0);
    rchk(usd_pkg::INT_STATUS_ADDR, 32'h8);
    wr(usd_pkg::INT_MASK_ADDR, 32'h8);
    check(32'(irq), 32'h1);
    wr(usd_pkg::INT_MASK_ADDR, 32'h0);
    for (int i = 0; i < 17; i++) P.send(1'b0, 8'(8'h80 + i));
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h3);
    for (int i = 0; i < 16; i++) rchk(usd_pkg::ALIAS_BASE_ADDR + 32'(4 * i), 32'h80 + i);
    rchk(usd_pkg::LINE_STATUS_ADDR, 32'h0);
    P.stall <= 1'b0;
    while (P.got.size() < 17) @(posedge aclk);
    repeat (20) @(posedge aclk);
    check(32'(P.got.size()), 32'h11);
    for (int i = 0; i < 16; i++) check(32'(P.got[i + 1]), 32'(i));
  endtask : t_fifo

  // ****************************************
  // Run control
  // ****************************************
  task automatic conclude();
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // A hang counts as a mismatch
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_idle();
    t_rx();
    t_tx();
    t_fifo();
    conclude();
  end
endmodule : test_uart_shadow_data_port

bind usd_shadow_data_port usd_monitor u_monitor (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .tx_valid(tx_valid));

/* File: testbench/usd_monitor.sv */
`timescale 1ns/1ps
// ****************************************
// Bus and transmit checks at the top ports
// ****************************************
module usd_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        tx_valid
);
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_BVALID_HOLD:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
  AST_RVALID_HOLD:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed while held");
  AST_RDATA_UPPER:
    assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits not zero");
  AST_AR_TO_R:
    assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  AST_W_TO_B:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
  AST_ARREADY:
    assert property (arready != rvalid) else $error("arready not inverse of rvalid");
  AST_TX_ROSE:
    assert property ($rose(tx_valid) |-> $rose(bvalid)) else $error("tx byte without a write");
  AST_ALIAS_OKAY:
    assert property (arvalid && arready && araddr >= usd_pkg::ALIAS_BASE_ADDR
      && araddr <= usd_pkg::ALIAS_LAST_ADDR && araddr[1:0] == 2'h0
      |=> rresp == usd_pkg::RESP_OKAY) else $error("alias read refused");
  AST_UNMAPPED:
    assert property (arvalid && arready && araddr > usd_pkg::INT_MASK_ADDR
      |=> rresp == usd_pkg::RESP_SLVERR && rdata == 32'h0) else $error("unmapped read accepted");
endmodule : usd_monitor

/* File: testbench/usd_serial_partner.sv */
`timescale 1ns/1ps
// ****************************************
// Remote serial device
// ****************************************
module usd_serial_partner (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  output logic            rx_uart_valid,
  output logic [7:0]      rx_uart_byte,
  output logic            rx_ir_valid,
  output logic [7:0]      rx_ir_byte
);
  logic       stall = 1'b0;
  logic [7:0] got[$];

  initial begin
    tx_ready = 1'b0;
    rx_uart_valid = 1'b0;
    rx_ir_valid = 1'b0;
    rx_uart_byte = 8'h00;
    rx_ir_byte = 8'h00;
  end

  // Ready lags the stall request a cycle, like a busy serialiser
  always @(posedge aclk) begin
    tx_ready <= aresetn && !stall;
    if (aresetn && tx_valid && tx_ready) got.push_back(tx_byte);
  end

  // One received byte; the byte lines show its inverse once released
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge aclk);
    rx_ir_valid <= ir;
    rx_uart_valid <= !ir;
    rx_ir_byte <= b;
    rx_uart_byte <= b;
    @(posedge aclk);
    rx_ir_valid <= 1'b0;
    rx_uart_valid <= 1'b0;
    rx_ir_byte <= ~b;
    rx_uart_byte <= ~b;
  endtask : send
endmodule : usd_serial_partner
